// *** verilog/rtc_ctrl.v ***
// Control registers, status flags and serial access port of the real-time clock
`timescale 1ns/1ns
`include "rtc_defs.vh"

module rtc_ctrl #(
    parameter [23:0] ALM_LONG_CYC = `ALM_LONG_US * `CLK_MHZ, // Alarm delay, 32 kHz and 1 MHz
    parameter [23:0] ALM_MID_CYC = `ALM_MID_US * `CLK_MHZ, // Alarm delay, 2 MHz
    parameter [23:0] ALM_SHORT_CYC = `ALM_SHORT_US * `CLK_MHZ, // Alarm delay, 4 MHz
    parameter [23:0] WD_TIMEOUT_CYC = `WD_TIMEOUT_US * `CLK_MHZ, // Watchdog window
    parameter [23:0] WD_PULSE_CYC = `WD_PULSE_US * `CLK_MHZ // CPU reset pulse length
) (
    input wire clk, // System clock, 125 MHz
    input wire rst_n, // Power-on reset, asynchronous, active low
    input wire ce, // Clock enable, freezes all state when low
    input wire por_pin_n, // Power-on reset pin level
    input wire ss, // Slave select, active high
    input wire sck, // Serial clock
    input wire mosi, // Serial data in
    output wire miso_o, // Serial data out
    output wire miso_oe, // Serial data out enable
    input wire osc_in, // Oscillator level
    input wire line_in, // Mains sense level
    input wire system_supply_sense, // System supply present
    input wire power_fail, // Power failure seen on the mains sense
    input wire alarm_match, // Time counters equal alarm latches
    input wire min_tick, // Minute rollover pulse from the calendar
    input wire hour_tick, // Hour rollover pulse from the calendar
    input wire day_tick, // Day rollover pulse from the calendar
    input wire [7:0] cal_rdata, // Calendar read data for cal_addr
    output reg [3:0] cal_addr, // Calendar location
    output reg [7:0] cal_wdata, // Calendar write data
    output reg cal_we, // Calendar write pulse
    output wire sec_tick, // One-second pulse to the calendar
    output wire cpu_reset_out_o, // CPU reset level when driven
    output wire cpu_reset_out_oe, // CPU reset pulled low
    output wire irq_n_o, // Interrupt level when driven
    output wire irq_n_oe, // Interrupt pulled low
    output wire supply_enable_out, // Power supply enable
    output wire square_wave_out // Selected square wave
);

wire [11:0] sq;
wire [11:0] sq_rise;
wire line_rise;
wire [2:0] odiv;
wire [7:0] ram_rdata;
reg [7:0] tbc_ff;
reg [7:0] ipc_ff;
reg ss_prev_ff;
reg sck_prev_ff;
reg cpol_ff;
reg [2:0] cnt_ff;
reg [7:0] rx_ff;
reg [7:0] tx_ff;
reg [7:0] rdbuf_ff;
reg have_adr_ff;
reg wr_ff;
reg bad_ff;
reg oe_ff;
reg xfer_ff;
reg [5:0] adr_ff;
reg [1:0] rd_pipe_ff;
reg wd_st_ff;
reg ftu_ff;
reg ps_st_ff;
reg alm_st_ff;
reg per_st_ff;
reg irq_ff;
reg alm_prev_ff;
reg alm_busy_ff;
reg [23:0] alm_cnt_ff;
reg [23:0] wd_cnt_ff;
reg [23:0] rst_cnt_ff;
reg system_supply_sense_prev_ff;
reg started_ff;
reg pse_ff;
reg cpu_rst_ff;
reg sq_out_ff;
reg per_evt;
reg cko_sel;
reg [23:0] alm_lim;

wire line_mode = tbc_ff[`TBC_LINE];
wire [1:0] xsel = tbc_ff[`TBC_XSEL_HI:`TBC_XSEL_LO];
wire [2:0] cko = tbc_ff[`TBC_CKO_HI:0];
wire [3:0] per_sel = ipc_ff[`IPC_PER_HI:0];
wire [3:0] per_idx = per_sel - `PER_ONE;
wire pd = ipc_ff[`IPC_PD];

// ****************************************
// Timebase and line divider
// ****************************************
rtc_tbase u_tbase (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .osc_in(osc_in),
    .line_in(line_in),
    .xsel(xsel),
    .line_mode(line_mode),
    .hz50(tbc_ff[`TBC_HZ50]),
    .run(tbc_ff[`TBC_RUN]),
    .psense(ipc_ff[`IPC_PS]),
    .sq(sq),
    .sq_rise(sq_rise),
    .line_rise(line_rise),
    .odiv(odiv)
);

// ****************************************
// Serial port decode
// ****************************************
wire ss_en = ss & ~pd;
wire ss_rise = ss_en & ~ss_prev_ff;
wire ss_fall = ~ss_en & ss_prev_ff;
wire sck_rise = sck & ~sck_prev_ff;
wire sck_fall = ~sck & sck_prev_ff;
wire latch_edge = ss_en & ~ss_rise & (cpol_ff ? sck_fall : sck_rise);
wire shift_edge = ss_en & ~ss_rise & (cpol_ff ? sck_rise : sck_fall);
wire byte_done = latch_edge & (cnt_ff == 3'h7);
wire [7:0] rx_byte = {rx_ff[6:0], mosi};
wire adr_done = byte_done & ~have_adr_ff;
wire dat_done = byte_done & have_adr_ff;
wire data_wr = dat_done & wr_ff & ~bad_ff;
wire tbc_wr = data_wr & (adr_ff == `ADR_TBC);
wire ipc_wr = data_wr & (adr_ff == `ADR_IPC);
wire ram_we = data_wr & ~adr_ff[5];
wire tx_load = shift_edge & have_adr_ff & ~wr_ff & ~bad_ff & (cnt_ff == 3'h0);
wire stat_rd = tx_load & (adr_ff == `ADR_STAT);
wire [5:0] adr_nxt = ~adr_ff[5] ? {1'b0, adr_ff[4:0] + `RAM_ONE} :
    (adr_ff == `ADR_IPC) ? `ADR_CLK_FIRST : adr_ff + `ADR_ONE;
wire int_true = ps_st_ff | alm_st_ff | per_st_ff;
wire [7:0] status = {1'b0, wd_st_ff, 1'b0, ftu_ff, int_true, ps_st_ff, alm_st_ff, per_st_ff};
wire [7:0] clk_rd = (adr_ff == `ADR_TBC) ? tbc_ff : (adr_ff == `ADR_IPC) ? ipc_ff :
    (adr_ff < `ADR_STAT) ? cal_rdata : `BYTE_ZERO;
wire [7:0] rd_mux = adr_ff[5] ? clk_rd : ram_rdata;
// Status is taken live at load so the read and its clear see one snapshot
wire [7:0] tx_src = (adr_ff == `ADR_STAT) ? status : rdbuf_ff;

rtc_ram u_ram (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .we(ram_we),
    .addr(adr_ff[4:0]),
    .wdata(rx_byte),
    .rdata(ram_rdata)
);

assign miso_o = tx_ff[7];
assign miso_oe = oe_ff;

// ****************************************
// Serial shift, address and burst logic
// ****************************************
always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        ss_prev_ff <= 1'b0;
        sck_prev_ff <= 1'b0;
        cpol_ff <= 1'b0;
        cnt_ff <= 3'h0;
        rx_ff <= `BYTE_ZERO;
        tx_ff <= `BYTE_ZERO;
        rdbuf_ff <= `BYTE_ZERO;
        have_adr_ff <= 1'b0;
        wr_ff <= 1'b0;
        bad_ff <= 1'b0;
        oe_ff <= 1'b0;
        xfer_ff <= 1'b0;
        adr_ff <= 6'h00;
        rd_pipe_ff <= 2'b00;
        cal_addr <= 4'h0;
        cal_wdata <= `BYTE_ZERO;
        cal_we <= 1'b0;
    end
    else if (ce)
    begin
        ss_prev_ff <= ss_en;
        sck_prev_ff <= sck;
        cal_we <= data_wr & adr_ff[5] & ~adr_ff[4];
        cal_addr <= adr_ff[3:0];
        cal_wdata <= rx_byte;
        rd_pipe_ff <= {rd_pipe_ff[0], 1'b0};
        if (rd_pipe_ff[1])
            rdbuf_ff <= rd_mux;
        if (!ss_en)
        begin
            cnt_ff <= 3'h0;
            have_adr_ff <= 1'b0;
            oe_ff <= 1'b0;
            xfer_ff <= 1'b0;
        end
        else
        begin
            if (ss_rise)
                cpol_ff <= sck;
            if (latch_edge)
            begin
                rx_ff <= rx_byte;
                cnt_ff <= cnt_ff + 3'h1;
            end
            if (adr_done)
            begin
                have_adr_ff <= 1'b1;
                wr_ff <= rx_byte[`AB_WRITE];
                bad_ff <= rx_byte[`AB_MUST_ZERO];
                adr_ff <= rx_byte[5:0];
                rd_pipe_ff <= {rd_pipe_ff[0], ~rx_byte[`AB_WRITE]};
            end
            if (dat_done)
            begin
                xfer_ff <= 1'b1;
                adr_ff <= adr_nxt;
                rd_pipe_ff <= {rd_pipe_ff[0], ~wr_ff};
            end
            if (tx_load)
            begin
                tx_ff <= tx_src;
                oe_ff <= 1'b1;
            end
            else if (shift_edge)
                tx_ff <= {tx_ff[6:0], 1'b0};
        end
    end
end

// ****************************************
// Event sources
// ****************************************
always @*
begin
    case (per_sel)
        `PER_OFF: per_evt = 1'b0;
        `PER_LINE: per_evt = line_mode ? line_rise : sq_rise[per_idx];
        `PER_2HZ, `PER_1HZ: per_evt = sq_rise[per_idx];
        `PER_MIN: per_evt = min_tick;
        `PER_HOUR: per_evt = hour_tick;
        `PER_DAY: per_evt = day_tick;
        default: per_evt = ~line_mode & sq_rise[per_idx];
    endcase
end

always @*
begin
    case (xsel)
        `XS_4M: alm_lim = ALM_SHORT_CYC - `CNT_ONE;
        `XS_2M: alm_lim = ALM_MID_CYC - `CNT_ONE;
        default: alm_lim = ALM_LONG_CYC - `CNT_ONE;
    endcase
    if (line_mode)
        alm_lim = ALM_LONG_CYC - `CNT_ONE;
end

always @*
begin
    case (cko)
        `CKO_OSC: cko_sel = osc_in;
        `CKO_DIV2: cko_sel = odiv[0];
        `CKO_DIV4: cko_sel = odiv[1];
        `CKO_DIV8: cko_sel = odiv[2];
        `CKO_LOW: cko_sel = 1'b0;
        `CKO_1HZ: cko_sel = sq[`SQ_1HZ];
        `CKO_2HZ: cko_sel = sq[`SQ_2HZ];
        default: cko_sel = line_mode ? line_in : sq[`SQ_64HZ];
    endcase
end

wire alm_start = ipc_ff[`IPC_ALM] & alarm_match & ~alm_prev_ff;
wire alm_evt = alm_busy_ff & (alm_cnt_ff == alm_lim);
wire ps_evt = ipc_ff[`IPC_PS] & ~ps_st_ff & power_fail;
wire irq_evt = ps_evt | alm_evt | per_evt;
wire wd_kick = ss_fall & ~xfer_ff;
wire wd_expire = ipc_ff[`IPC_WD] & (wd_cnt_ff == WD_TIMEOUT_CYC - `CNT_ONE);
// Supply return always powers up; an interrupt powers up only out of power-down
wire pwr_up = system_supply_sense & (~system_supply_sense_prev_ff | (pd & irq_evt));
// Power-down takes effect at the writing edge, not one cycle later
wire pd_now = pd | (ipc_wr & rx_byte[`IPC_PD]);

assign sec_tick = sq_rise[`SQ_1HZ];
assign irq_n_o = 1'b0;
assign irq_n_oe = irq_ff;
assign cpu_reset_out_o = 1'b0;
assign cpu_reset_out_oe = cpu_rst_ff;
assign supply_enable_out = pse_ff;
assign square_wave_out = sq_out_ff;

// ****************************************
// Control registers, status flags and power sequencing
// ****************************************
always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        tbc_ff <= `TBC_RESET;
        ipc_ff <= `IPC_RESET;
        wd_st_ff <= 1'b0;
        ftu_ff <= 1'b1;
        ps_st_ff <= 1'b0;
        alm_st_ff <= 1'b0;
        per_st_ff <= 1'b0;
        irq_ff <= 1'b0;
        alm_prev_ff <= 1'b0;
        alm_busy_ff <= 1'b0;
        alm_cnt_ff <= `CNT_ZERO;
        wd_cnt_ff <= `CNT_ZERO;
        rst_cnt_ff <= `CNT_ZERO;
        system_supply_sense_prev_ff <= 1'b0;
        started_ff <= 1'b0;
        pse_ff <= 1'b0;
        cpu_rst_ff <= 1'b0;
        sq_out_ff <= 1'b0;
    end
    else if (ce)
    begin
        alm_prev_ff <= alarm_match;
        system_supply_sense_prev_ff <= system_supply_sense;
        started_ff <= 1'b1;
        if (tbc_wr)
            tbc_ff <= rx_byte;
        if (ipc_wr)
            ipc_ff <= rx_byte;
        else if (pwr_up)
            ipc_ff[`IPC_PD] <= 1'b0;
        ps_st_ff <= ps_evt | (ps_st_ff & ~(ipc_wr & ~rx_byte[`IPC_PS]));
        alm_st_ff <= alm_evt | (alm_st_ff & ~stat_rd);
        per_st_ff <= per_evt | (per_st_ff & ~stat_rd);
        wd_st_ff <= wd_expire | (wd_st_ff & ~stat_rd);
        ftu_ff <= ftu_ff & ~(stat_rd & por_pin_n);
        irq_ff <= irq_evt | (irq_ff & ~stat_rd);
        if (alm_start)
        begin
            alm_busy_ff <= 1'b1;
            alm_cnt_ff <= `CNT_ZERO;
        end
        else if (alm_evt || !ipc_ff[`IPC_ALM])
            alm_busy_ff <= 1'b0;
        else if (alm_busy_ff)
            alm_cnt_ff <= alm_cnt_ff + `CNT_ONE;
        if (!ipc_ff[`IPC_WD] || wd_kick || wd_expire)
            wd_cnt_ff <= `CNT_ZERO;
        else
            wd_cnt_ff <= wd_cnt_ff + `CNT_ONE;
        if (wd_expire)
            rst_cnt_ff <= WD_PULSE_CYC;
        else if (rst_cnt_ff != `CNT_ZERO)
            rst_cnt_ff <= rst_cnt_ff - `CNT_ONE;
        cpu_rst_ff <= wd_expire | (rst_cnt_ff > `CNT_ONE) | pd_now | ~system_supply_sense;
        if (!system_supply_sense || (ipc_wr && rx_byte[`IPC_PD]))
            pse_ff <= 1'b0;
        else if (!started_ff || pwr_up)
            pse_ff <= 1'b1;
        sq_out_ff <= cko_sel & ~pd_now & system_supply_sense;
    end
end

endmodule

// *** pkg/rtc_defs.vh ***
// Shared constants of the real-time clock control and serial access block
`ifndef RTC_DEFS_VH
`define RTC_DEFS_VH

// ****************************************
// Register locations in clock space
// ****************************************
`define ADR_STAT 6'h30
`define ADR_TBC 6'h31
`define ADR_IPC 6'h32
`define ADR_CLK_FIRST 6'h20
`define ADR_ONE 6'h01
`define RAM_ONE 5'h01

// ****************************************
// Address byte fields
// ****************************************
`define AB_WRITE 7
`define AB_MUST_ZERO 6

// ****************************************
// timebase_control fields
// ****************************************
`define TBC_RUN 7
`define TBC_LINE 6
`define TBC_XSEL_HI 5
`define TBC_XSEL_LO 4
`define TBC_HZ50 3
`define TBC_CKO_HI 2
`define TBC_RESET 8'h00

// ****************************************
// irq_power_control fields
// ****************************************
`define IPC_WD 7
`define IPC_PD 6
`define IPC_PS 5
`define IPC_ALM 4
`define IPC_PER_HI 3
`define IPC_RESET 8'h00

// ****************************************
// Periodic select and clock-out codes
// ****************************************
`define PER_OFF 4'h0
`define PER_LINE 4'h6
`define PER_2HZ 4'hB
`define PER_1HZ 4'hC
`define PER_MIN 4'hD
`define PER_HOUR 4'hE
`define PER_DAY 4'hF
`define PER_ONE 4'h1
`define CKO_OSC 3'h0
`define CKO_DIV2 3'h1
`define CKO_DIV4 3'h2
`define CKO_DIV8 3'h3
`define CKO_LOW 3'h4
`define CKO_1HZ 3'h5
`define CKO_2HZ 3'h6
`define CKO_64HZ 3'h7

// ****************************************
// Crystal codes and prescaler limits to the 4096 Hz tick
// ****************************************
`define XS_4M 2'h0
`define XS_2M 2'h1
`define XS_1M 2'h2
`define XS_32K 2'h3
`define PRE_4M 10'h3FF
`define PRE_2M 10'h1FF
`define PRE_1M 10'h0FF
`define PRE_32K 10'h007
`define PRE_ONE 10'h001
`define CHAIN_HOLD_MASK 12'h03F
`define CHAIN_ONE 12'h001
`define SQ_1HZ 11
`define SQ_2HZ 10
`define SQ_64HZ 5
`define LINE_DIV50 6'h32
`define LINE_DIV60 6'h3C
`define LCNT_ONE 6'h01

// ****************************************
// Times in microseconds and the clock rate in MHz
// ****************************************
`define CLK_MHZ 24'h00007D
`define ALM_LONG_US 24'h007724
`define ALM_MID_US 24'h003BC4
`define ALM_SHORT_US 24'h001DB0
`define WD_PULSE_US 24'h0061A8
`define WD_TIMEOUT_US 24'h0186A0
`define CNT_ZERO 24'h000000
`define CNT_ONE 24'h000001
`define BYTE_ZERO 8'h00

`endif

// *** verilog/rtc_ram.v ***
// General purpose 32 x 8 storage with registered read data
`timescale 1ns/1ns
`include "rtc_defs.vh"

module rtc_ram (
    input wire clk, // System clock
    input wire rst_n, // Asynchronous reset, active low
    input wire ce, // Clock enable
    input wire we, // Write strobe
    input wire [4:0] addr, // Location
    input wire [7:0] wdata, // Write data
    output reg [7:0] rdata // Read data, one cycle after addr
);

reg [7:0] mem [0:31];

always @(posedge clk)
begin
    if (ce && we)
        mem[addr] <= wdata;
end

always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
        rdata <= `BYTE_ZERO;
    else if (ce)
        rdata <= mem[addr];
end

endmodule

// *** verilog/rtc_tbase.v ***
// Oscillator prescaler, divider chain and line-frequency divider
`timescale 1ns/1ns
`include "rtc_defs.vh"

module rtc_tbase (
    input wire clk, // System clock
    input wire rst_n, // Asynchronous reset, active low
    input wire ce, // Clock enable
    input wire osc_in, // Oscillator level
    input wire line_in, // Mains sense level
    input wire [1:0] xsel, // Crystal select
    input wire line_mode, // Line timebase selected
    input wire hz50, // 50 Hz mains when high
    input wire run, // Divider chain running
    input wire psense, // Power sense disconnects the line prescaler
    output wire [11:0] sq, // Square waves, bit 0 2048 Hz to bit 11 1 Hz; only bits 10 and 11 toggle in line mode
    output wire [11:0] sq_rise, // Rising edges of sq
    output wire line_rise, // Line cycle pulse
    output wire [2:0] odiv // Oscillator divided by 2, 4, 8
);

reg osc_prev_ff;
reg line_prev_ff;
reg [9:0] pre_ff;
reg [11:0] chain_ff;
reg [11:0] sq_prev_ff;
reg [5:0] lcnt_ff;
reg [2:0] odiv_ff;
reg [9:0] pre_lim;

// ****************************************
// Prescale to 4096 Hz for the chosen crystal
// ****************************************
always @*
begin
    case (xsel)
        `XS_4M: pre_lim = `PRE_4M;
        `XS_2M: pre_lim = `PRE_2M;
        `XS_1M: pre_lim = `PRE_1M;
        default: pre_lim = `PRE_32K;
    endcase
end

wire osc_rise = osc_in & ~osc_prev_ff;
wire t4k = osc_rise & (pre_ff == pre_lim);
wire [11:0] nxt_chain = t4k ? chain_ff + `CHAIN_ONE : chain_ff;
wire [5:0] ldiv = hz50 ? `LINE_DIV50 : `LINE_DIV60;
wire [5:0] lhalf = {1'b0, ldiv[5:1]};
wire [5:0] lquart = {2'b00, ldiv[5:2]};
wire l_hi = (lcnt_ff >= lhalf);
wire [5:0] lpart = l_hi ? lcnt_ff - lhalf : lcnt_ff;

assign line_rise = line_in & ~line_prev_ff & ~psense;
assign sq = line_mode ? {l_hi, (lpart >= lquart), 10'h000} : chain_ff;
assign sq_rise = sq & ~sq_prev_ff;
assign odiv = odiv_ff;

always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        osc_prev_ff <= 1'b0;
        line_prev_ff <= 1'b0;
        pre_ff <= 10'h000;
        chain_ff <= 12'h000;
        sq_prev_ff <= 12'h000;
        lcnt_ff <= 6'h00;
        odiv_ff <= 3'h0;
    end
    else if (ce)
    begin
        osc_prev_ff <= osc_in;
        line_prev_ff <= line_in;
        sq_prev_ff <= sq;
        odiv_ff <= odiv_ff + {2'b00, osc_rise};
        if (osc_rise)
            pre_ff <= t4k ? 10'h000 : pre_ff + `PRE_ONE;
        chain_ff <= run ? nxt_chain : (nxt_chain & `CHAIN_HOLD_MASK);
        if (!run)
            lcnt_ff <= 6'h00;
        else if (line_rise)
            lcnt_ff <= (lcnt_ff == ldiv - `LCNT_ONE) ? 6'h00 : lcnt_ff + `LCNT_ONE;
    end
end

endmodule

// *** verif/rtc_chk_assertions.sv ***
// Checker for the serial port and output pins of rtc_ctrl
`timescale 1ns/1ns
module rtc_chk (
    input wire clk, // Clock
    input wire rst_n, // Reset
    input wire ss, // Select
    input wire sck, // Serial clock
    input wire miso_o, // Data out
    input wire miso_oe, // Data out enable
    input wire cal_we, // Calendar write
    input wire cpu_reset_out_o, // CPU reset level
    input wire cpu_reset_out_oe, // CPU reset enable
    input wire irq_n_o, // Interrupt level
    input wire irq_n_oe, // Interrupt enable
    input wire system_supply_sense, // Supply sense
    input wire supply_enable_out, // Supply enable
    input wire square_wave_out // Clock out
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence sck_still;
        $stable(sck) [*3];
    endsequence
    sequence ss_gone;
        !ss ##1 !ss;
    endsequence
    miso_off_a: assert property (ss_gone |=> !miso_oe)
        else $error("miso driven without select");
    miso_start_a: assert property ($rose(miso_oe) |-> ss && $past(ss))
        else $error("miso enabled outside a frame");
    miso_hold_a: assert property (sck_still ##0 (miso_oe && $past(miso_oe)) |-> $stable(miso_o))
        else $error("miso changed without a shift edge");
    irq_hold_a: assert property (irq_n_oe && !ss |=> irq_n_oe)
        else $error("interrupt released without status read");
    calwe_pulse_a: assert property (cal_we |=> !cal_we)
        else $error("calendar write longer than one cycle");
    od_low_a: assert property (cpu_reset_out_o == 1'b0 && irq_n_o == 1'b0)
        else $error("open drain level not low");
    supply_off_a: assert property (!system_supply_sense |=> !supply_enable_out && cpu_reset_out_oe)
        else $error("supply loss not followed");
    sq_gated_a: assert property (!supply_enable_out |-> !square_wave_out)
        else $error("clock out running while powered down");
endmodule

bind rtc_ctrl rtc_chk u_chk (.clk(clk), .rst_n(rst_n), .ss(ss), .sck(sck), .miso_o(miso_o),
    .miso_oe(miso_oe), .cal_we(cal_we), .cpu_reset_out_o(cpu_reset_out_o),
    .cpu_reset_out_oe(cpu_reset_out_oe), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe),
    .system_supply_sense(system_supply_sense), .supply_enable_out(supply_enable_out),
    .square_wave_out(square_wave_out));

// *** verif/rtc_host.sv ***
// Host model driving the serial port of rtc_ctrl
`timescale 1ns/1ns
module rtc_host (
    input wire clk, // Clock
    output reg ss, // Slave select
    output reg sck, // Serial clock
    output reg mosi, // Serial data out
    input wire miso_o, // Device data
    input wire miso_oe // Device drives data
);
    reg cpol;
    reg last;
    // Released line shows a changing pattern, never the stale bit
    wire miso_w = miso_oe ? miso_o : ~last;
    always @(posedge clk) last <= miso_w;
    initial
    begin
        cpol = 0;
        ss = 0;
        sck = 0;
        mosi = 0;
        last = 0;
    end
    task wait_n(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task sel;
        wait_n(1);
        sck = cpol;
        wait_n(2);
        ss = 1;
        wait_n(3);
    endtask
    task desel;
        wait_n(4);
        ss = 0;
        wait_n(4);
    endtask
    task xfer(input [7:0] tx, output [7:0] rx);
        integer i;
        for (i = 7; i >= 0; i = i - 1)
        begin
            mosi = tx[i];
            wait_n(4);
            sck = ~cpol;
            rx[i] = miso_w;
            wait_n(4);
            sck = cpol;
        end
    endtask
endmodule

// *** verif/tb_top.sv ***
// Self-checking testbench for rtc_ctrl
`timescale 1ns/1ns
module tb_top;
    reg clk, rst_n, por_pin_n, osc_in, system_supply_sense;
    reg ce, line_in, power_fail, alarm_match, min_tick, hour_tick, day_tick;
    reg [7:0] cal_rdata;
    wire ss, sck, mosi, miso_o, miso_oe, cal_we, cro, croe, irqo, irqoe, spe, sqw;
    wire [3:0] cal_addr;
    wire [7:0] cal_wdata;
    reg [3:0] cw_addr;
    reg [7:0] cw_data, rx, d;
    integer failures, num_checks, k;
    initial
    begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    initial
    begin
        osc_in = 0;
        forever #16 osc_in = ~osc_in;
    end
    always @(posedge clk) if (cal_we === 1'b1) {cw_addr, cw_data} <= {cal_addr, cal_wdata};
    rtc_ctrl #(.ALM_LONG_CYC(24'h000028), .ALM_MID_CYC(24'h000014), .ALM_SHORT_CYC(24'h00000A),
        .WD_TIMEOUT_CYC(24'h0000C8), .WD_PULSE_CYC(24'h00001E)) u_dut (
        .clk(clk), .rst_n(rst_n), .ce(ce), .por_pin_n(por_pin_n), .ss(ss), .sck(sck),
        .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe), .osc_in(osc_in), .line_in(line_in),
        .system_supply_sense(system_supply_sense), .power_fail(power_fail),
        .alarm_match(alarm_match), .min_tick(min_tick), .hour_tick(hour_tick),
        .day_tick(day_tick), .cal_rdata(cal_rdata),
        .cal_addr(cal_addr), .cal_wdata(cal_wdata), .cal_we(cal_we), .sec_tick(),
        .cpu_reset_out_o(cro), .cpu_reset_out_oe(croe), .irq_n_o(irqo), .irq_n_oe(irqoe),
        .supply_enable_out(spe), .square_wave_out(sqw));
    rtc_host u_host (.clk(clk), .ss(ss), .sck(sck), .mosi(mosi), .miso_o(miso_o),
        .miso_oe(miso_oe));
    task chk(input [95:0] nm, input [7:0] exp, input [7:0] got);
        num_checks = num_checks + 1;
        if (got !== exp)
        begin
            failures = failures + 1;
            $display("Error %0s expected %h seen %h", nm, exp, got);
        end
    endtask
    task wr(input [7:0] a, input [7:0] v);
        u_host.sel;
        u_host.xfer(a, rx);
        u_host.xfer(v, rx);
        u_host.desel;
    endtask
    task rd(input [7:0] a, output [7:0] v);
        u_host.sel;
        u_host.xfer(a, rx);
        u_host.xfer(8'h00, v);
        u_host.desel;
    endtask
    task end_of_test;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task t_reset;
        rd(8'h31, d);
        chk("tbc", 8'h00, d);
        rd(8'h32, d);
        chk("ipc", 8'h00, d);
        rd(8'h30, d);
        chk("stat", 8'h10, d);
        rd(8'h30, d);
        chk("stat_por", 8'h10, d);
        $display("t_reset done");
    endtask
    task t_regs;
        wr(8'hB1, 8'hB0);
        u_host.cpol = 1;
        rd(8'h31, d);
        chk("tbc_cpol1", 8'hB0, d);
        u_host.cpol = 0;
        u_host.sel;
        u_host.xfer(8'hB2, rx);
        u_host.xfer(8'h00, rx);
        u_host.xfer(8'h5A, rx);
        u_host.desel;
        chk("wrap_addr", 8'h00, {4'h0, cw_addr});
        chk("wrap_data", 8'h5A, cw_data);
        rd(8'h32, d);
        chk("ipc_back", 8'h00, d);
        rd(8'h21, d);
        chk("cal_rd", 8'hC3, d);
        $display("t_regs done");
    endtask
    task t_ftu;
        por_pin_n = 1;
        wr(8'hB0, 8'hFF);
        rd(8'h30, d);
        chk("stat_ro", 8'h10, d);
        rd(8'h30, d);
        chk("ftu_clear", 8'h00, d);
        $display("t_ftu done");
    endtask
    task t_per;
        wr(8'hB2, 8'h01);
        k = 0;
        while (k < 4000 && irqoe !== 1'b1)
        begin
            u_host.wait_n(1);
            k = k + 1;
        end
        chk("irq_up", 8'h01, {7'h00, irqoe});
        if (irqoe !== 1'b1)
            end_of_test;
        wr(8'hB2, 8'h00);
        chk("irq_held", 8'h01, {7'h00, irqoe});
        rd(8'h30, d);
        chk("stat_per", 8'h09, d);
        chk("irq_off", 8'h00, {7'h00, irqoe});
        rd(8'h30, d);
        chk("stat_clr", 8'h00, d);
        $display("t_per done");
    endtask
    task t_pd;
        wr(8'hB2, 8'h40);
        u_host.wait_n(2);
        chk("pd_supply", 8'h00, {7'h00, spe});
        chk("pd_reset", 8'h01, {7'h00, croe});
        system_supply_sense = 0;
        u_host.wait_n(4);
        system_supply_sense = 1;
        u_host.wait_n(8);
        chk("up_supply", 8'h01, {7'h00, spe});
        chk("up_reset", 8'h00, {7'h00, croe});
        rd(8'h31, d);
        chk("up_port", 8'hB0, d);
        $display("t_pd done");
    endtask
    task t_alm;
        wr(8'hB2, 8'h10);
        alarm_match = 1;
        u_host.wait_n(30);
        chk("alm_early", 8'h00, {7'h00, irqoe});
        u_host.wait_n(20);
        chk("alm_irq", 8'h01, {7'h00, irqoe});
        alarm_match = 0;
        rd(8'h30, d);
        chk("stat_alm", 8'h0A, d);
        wr(8'hB2, 8'h00);
        chk("alm_irq_off", 8'h00, {7'h00, irqoe});
        $display("t_alm done");
    endtask
    task t_ps;
        wr(8'hB2, 8'h20);
        power_fail = 1;
        u_host.wait_n(2);
        power_fail = 0;
        chk("ps_irq", 8'h01, {7'h00, irqoe});
        rd(8'h30, d);
        chk("stat_ps", 8'h0C, d);
        rd(8'h30, d);
        chk("ps_kept", 8'h0C, d);
        chk("ps_irq_off", 8'h00, {7'h00, irqoe});
        wr(8'hB2, 8'h00);
        rd(8'h30, d);
        chk("ps_rearm", 8'h00, d);
        $display("t_ps done");
    endtask
    task t_wd;
        wr(8'hB2, 8'h80);
        k = 0;
        while (k < 400 && croe !== 1'b1)
        begin
            u_host.wait_n(1);
            k = k + 1;
        end
        chk("wd_reset", 8'h01, {7'h00, croe});
        if (croe !== 1'b1)
            end_of_test;
        k = 0;
        while (k < 100 && croe === 1'b1)
        begin
            u_host.wait_n(1);
            k = k + 1;
        end
        chk("wd_pulse", 8'h1E, k[7:0]);
        wr(8'hB2, 8'h00);
        rd(8'h30, d);
        chk("stat_wd", 8'h40, d);
        $display("t_wd done");
    endtask
    initial
    begin
        failures = 0;
        num_checks = 0;
        rst_n = 0;
        por_pin_n = 0;
        system_supply_sense = 1;
        ce = 1;
        {line_in, power_fail, alarm_match, min_tick, hour_tick, day_tick} = 6'h00;
        cal_rdata = 8'hC3;
        repeat (12) @(posedge clk);
        #1 rst_n = 1;
        t_reset;
        t_regs;
        t_ftu;
        t_per;
        t_alm;
        t_ps;
        t_wd;
        t_pd;
        end_of_test;
    end
endmodule
